// *** ppgx_pkg.sv ***
// Package for the program page expansion block: page window bounds,
// partition thresholds, fixed extended address values and sequencer codes.
// Assumes a 16-bit core address and a six-bit page index.
package ppgx_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int PPGX_PAGE_W = 6;
  localparam int PPGX_ADDR_W = 16;
  // ---------------------------------------------------------------
  // Address quadrants (top two address bits)
  // ---------------------------------------------------------------
  localparam logic [1:0] PPGX_QUAD_LOW = 2'h0;
  localparam logic [1:0] PPGX_QUAD_MID = 2'h1;
  localparam logic [1:0] PPGX_QUAD_WIN = 2'h2;
  localparam logic [1:0] PPGX_QUAD_TOP = 2'h3;
  // ---------------------------------------------------------------
  // Fixed extended address values outside the window
  // ---------------------------------------------------------------
  localparam logic [5:0] PPGX_XA_LOW = 6'h3d;
  localparam logic [5:0] PPGX_XA_MID = 6'h3e;
  localparam logic [5:0] PPGX_XA_TOP = 6'h3f;
  // ---------------------------------------------------------------
  // Partition select codes and internal page thresholds
  // ---------------------------------------------------------------
  localparam logic [1:0] PPGX_PART_128K = 2'h0;
  localparam logic [1:0] PPGX_PART_256K = 2'h1;
  localparam logic [1:0] PPGX_PART_512K = 2'h2;
  localparam logic [1:0] PPGX_PART_1M = 2'h3;
  localparam logic [5:0] PPGX_THR_128K = 6'h38;
  localparam logic [5:0] PPGX_THR_256K = 6'h30;
  localparam logic [5:0] PPGX_THR_512K = 6'h20;
  localparam logic [5:0] PPGX_THR_1M = 6'h00;
  // ---------------------------------------------------------------
  // Allocated flash/ROM size codes
  // ---------------------------------------------------------------
  localparam logic [1:0] PPGX_ALLOC_0K = 2'h0;
  localparam logic [1:0] PPGX_ALLOC_16K = 2'h1;
  localparam logic [1:0] PPGX_ALLOC_48K = 2'h2;
  localparam logic [1:0] PPGX_ALLOC_64K = 2'h3;
  // ---------------------------------------------------------------
  // Reset values of page index, address and byte registers
  // ---------------------------------------------------------------
  localparam logic [5:0] PPGX_PAGE_RST = 6'h00;
  localparam logic [15:0] PPGX_ADDR_RST = 16'h0000;
  localparam logic [7:0] PPGX_BYTE_RST = 8'h00;
  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PPGX_IDLE,
    PPGX_CALL_RETHI,
    PPGX_RTC_WAIT,
    PPGX_CALL_PAGE,
    PPGX_CALL_JUMP,
    PPGX_RTC_RETHI,
    PPGX_RTC_RETLO,
    PPGX_RTC_DONE
  } ppgx_state_e;
endpackage

// *** ppgx_window_class.sv ***
// Window access classifier: decides internal or external page access
// from the partition select. Assumes partition is static after reset.
`timescale 1ns/100ps
`default_nettype none
module ppgx_window_class
  import ppgx_pkg::*;
(
  input wire logic [1:0] partitionSelect,
  input wire logic [5:0] pageIndexBits,
  output logic pageInternal
);
  // ---------------------------------------------------------------
  // Threshold select and compare
  // ---------------------------------------------------------------
  // Threshold per partition split
  wire logic [5:0] threshold = (partitionSelect == PPGX_PART_128K) ? PPGX_THR_128K :
    (partitionSelect == PPGX_PART_256K) ? PPGX_THR_256K :
    (partitionSelect == PPGX_PART_512K) ? PPGX_THR_512K : PPGX_THR_1M;
  assign pageInternal = (pageIndexBits >= threshold);
endmodule
`default_nettype wire

// *** ppgx_ext_decode.sv ***
// Extended address and emulation select decoder for one core address.
// Assumes allocated size and ROM high-map bit are stable configuration.
`timescale 1ns/100ps
`default_nettype none
module ppgx_ext_decode
  import ppgx_pkg::*;
(
  input wire logic [1:0] quadrant,
  input wire logic [5:0] pageIndexBits,
  input wire logic pageInternal,
  input wire logic [1:0] allocSize,
  input wire logic romHighMapHide,
  output logic [5:0] extAddrHigh,
  output logic emuSelect
);
  // ---------------------------------------------------------------
  // Extended address bits 19:14
  // ---------------------------------------------------------------
  assign extAddrHigh = (quadrant == PPGX_QUAD_WIN) ? pageIndexBits :
    (quadrant == PPGX_QUAD_LOW) ? PPGX_XA_LOW :
    (quadrant == PPGX_QUAD_MID) ? PPGX_XA_MID : PPGX_XA_TOP;
  // ---------------------------------------------------------------
  // Emulation select (active high here) per allocation
  // ---------------------------------------------------------------
  wire logic inTop = (quadrant == PPGX_QUAD_TOP);
  wire logic inWin = (quadrant == PPGX_QUAD_WIN);
  wire logic inMid = (quadrant == PPGX_QUAD_MID);
  wire logic inLow = (quadrant == PPGX_QUAD_LOW);
  wire logic sel0k = inTop | inWin;
  wire logic sel16k = inTop;
  wire logic sel48k = inTop | (inWin & pageInternal) | (inMid & ~romHighMapHide);
  wire logic sel64k = inTop | (inWin & pageInternal) | ((inMid | inLow) & ~romHighMapHide);
  assign emuSelect = (allocSize == PPGX_ALLOC_0K) ? sel0k :
    (allocSize == PPGX_ALLOC_16K) ? sel16k :
    (allocSize == PPGX_ALLOC_48K) ? sel48k : sel64k;
endmodule
`default_nettype wire

// *** ppgx_program_page.sv ***
// Program page expansion: page index register, far call / far return
// page sequencing and external address / chip select generation.
// Assumes the core supplies one-cycle call and return starts, stack
// pull data, and holds its address stable per cycle.
//
// Summary of operation
// - Six-bit page index maps one of 64 16K pages into 0x8000-0xBFFF.
// - Two-bit partition select sets off-chip/on-chip split of paged space.
// - Window page internal at or above 0x38, 0x30, 0x20, or always.
// - Page index updated by normal writes and by call/return sequences.
// - Far call saves old page to temp, then loads instruction page.
// - Far call pushes 16-bit return address, then old page value.
// - Far call ends by jumping to target in newly selected page.
// - Far call sequence cannot be interrupted.
// - Page from immediate, or from memory via pointer in indexed-indirect.
// - Far return pulls page, then return address into PC, restores page.
// - Far return uninterruptible and works from any location.
// - Window access in expanded emulation drives page bits on lines 19:14.
// - Outside window, lines 19:14 carry 0x3D, 0x3E or 0x3F.
// - With 0K allocated, emulation select asserts for 0x8000-0xFFFF.
// - With 16K allocated, emulation select asserts only for 0xC000-0xFFFF.
// - With 48K, mid block gated by high-map, window internal only, top always.
// - With 64K, low half gated by high-map, window internal only, top always.
// - Extended lines and emulation select go out only when enabled and expanded.
// - External select asserts only when emulation select idle and space external.
// - Normal page write effective next cycle; call/return update before end.
`timescale 1ns/100ps
`default_nettype none
module ppgx_program_page
  import ppgx_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  // Configuration, static after reset
  input wire logic [1:0] partitionSelect,
  input wire logic [1:0] allocSize,
  input wire logic romHighMapHide,
  input wire logic emulationPortEnable,
  input wire logic expandedMode,
  // Ordinary page index access
  input wire logic pageWrite,
  input wire logic [5:0] pageWriteData,
  output logic [5:0] programPageIndex,
  // Core address and external space qualifier
  input wire logic [15:0] coreAddr,
  input wire logic addrValid,
  input wire logic extSpace,
  // Far call request
  input wire logic callStart,
  input wire logic [5:0] callPage,
  input wire logic [15:0] callTarget,
  input wire logic [15:0] callReturnAddr,
  // Far return request and stack pull data
  input wire logic rtcStart,
  input wire logic [7:0] pullData,
  // Stack and program counter outputs
  output logic pushValid,
  output logic [7:0] pushData,
  output logic pullReq,
  output logic pcLoad,
  output logic [15:0] pcValue,
  output logic queueRefill,
  output logic seqBusy,
  output logic irqBlock,
  // External pins
  output logic [5:0] extendedAddrHigh,
  output logic extAddrOe,
  output logic emuChipSelectN,
  output logic extChipSelectN
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  ppgx_state_e state_q, state_d;
  logic [5:0] page_q, page_d;
  logic [5:0] tempPage_q, tempPage_d;
  logic [15:0] retAddr_q, retAddr_d;
  logic [15:0] target_q, target_d;
  logic [7:0] retHi_q, retHi_d;
  logic pushValid_q, pushValid_d;
  logic [7:0] pushData_q, pushData_d;
  logic pullReq_q, pullReq_d;
  logic pcLoad_q, pcLoad_d;
  logic [15:0] pcValue_q, pcValue_d;
  logic queueRefill_q, queueRefill_d;
  logic busy_q;
  logic [5:0] xa_q;
  logic xaOe_q;
  logic ecsN_q;
  logic xcsN_q;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire logic [1:0] quadrant = coreAddr[PPGX_ADDR_W-1:PPGX_ADDR_W-2];
  wire logic pinsEnabled = emulationPortEnable & expandedMode;
  wire logic pageInternal;
  wire logic [5:0] xaNext;
  wire logic emuSel;
  wire logic emuActive = pinsEnabled & addrValid & emuSel;
  wire logic xcsActive = emulationPortEnable & addrValid & extSpace & ~emuActive;

  ppgx_window_class uClass (
    .partitionSelect(partitionSelect),
    .pageIndexBits(page_q),
    .pageInternal(pageInternal)
  );

  ppgx_ext_decode uDecode (
    .quadrant(quadrant),
    .pageIndexBits(page_q),
    .pageInternal(pageInternal),
    .allocSize(allocSize),
    .romHighMapHide(romHighMapHide),
    .extAddrHigh(xaNext),
    .emuSelect(emuSel)
  );

  // ---------------------------------------------------------------
  // Call / return sequencer
  // ---------------------------------------------------------------
  // Next-state and data path; page value comes from caller (immediate
  // or pointer fetch is the core's concern)
  always_comb
  begin
    state_d = state_q;
    page_d = page_q;
    tempPage_d = tempPage_q;
    retAddr_d = retAddr_q;
    target_d = target_q;
    retHi_d = retHi_q;
    pushValid_d = 1'b0;
    pushData_d = pushData_q;
    pullReq_d = 1'b0;
    pcLoad_d = 1'b0;
    pcValue_d = pcValue_q;
    queueRefill_d = 1'b0;
    case (state_q)
      PPGX_IDLE:
      begin
        if (callStart)
        begin
          tempPage_d = page_q;
          page_d = callPage;
          retAddr_d = callReturnAddr;
          target_d = callTarget;
          pushValid_d = 1'b1;
          pushData_d = callReturnAddr[7:0];
          state_d = PPGX_CALL_RETHI;
        end
        else if (rtcStart)
        begin
          pullReq_d = 1'b1;
          state_d = PPGX_RTC_WAIT;
        end
        else if (pageWrite)
        begin
          page_d = pageWriteData;
        end
      end
      PPGX_CALL_RETHI:
      begin
        pushValid_d = 1'b1;
        pushData_d = retAddr_q[15:8];
        state_d = PPGX_CALL_PAGE;
      end
      PPGX_CALL_PAGE:
      begin
        pushValid_d = 1'b1;
        pushData_d = {2'b00, tempPage_q};
        state_d = PPGX_CALL_JUMP;
      end
      PPGX_CALL_JUMP:
      begin
        pcLoad_d = 1'b1;
        pcValue_d = target_q;
        queueRefill_d = 1'b1;
        state_d = PPGX_IDLE;
      end
      // First pulled byte is still on its way; ask for the second
      PPGX_RTC_WAIT:
      begin
        pullReq_d = 1'h1;
        state_d = PPGX_RTC_RETHI;
      end
      PPGX_RTC_RETHI:
      begin
        tempPage_d = pullData[5:0];
        pullReq_d = 1'b1;
        state_d = PPGX_RTC_RETLO;
      end
      PPGX_RTC_RETLO:
      begin
        retHi_d = pullData;
        state_d = PPGX_RTC_DONE;
      end
      PPGX_RTC_DONE:
      begin
        pcLoad_d = 1'b1;
        pcValue_d = {retHi_q, pullData};
        page_d = tempPage_q;
        queueRefill_d = 1'b1;
        state_d = PPGX_IDLE;
      end
      default:
      begin
        state_d = PPGX_IDLE;
      end
    endcase
  end

  // Busy flag registered so the pin comes straight from a flop
  wire logic busy_d = (state_d != PPGX_IDLE);

  // Sequencer state and page registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= PPGX_IDLE;
      page_q <= PPGX_PAGE_RST;
      tempPage_q <= PPGX_PAGE_RST;
      retAddr_q <= PPGX_ADDR_RST;
      target_q <= PPGX_ADDR_RST;
      retHi_q <= PPGX_BYTE_RST;
      busy_q <= 1'h0;
    end
    else
    begin
      state_q <= state_d;
      page_q <= page_d;
      tempPage_q <= tempPage_d;
      retAddr_q <= retAddr_d;
      target_q <= target_d;
      retHi_q <= retHi_d;
      busy_q <= busy_d;
    end
  end

  // Stack and PC strobes
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pushValid_q <= 1'b0;
      pushData_q <= PPGX_BYTE_RST;
      pullReq_q <= 1'b0;
      pcLoad_q <= 1'b0;
      pcValue_q <= PPGX_ADDR_RST;
      queueRefill_q <= 1'b0;
    end
    else
    begin
      pushValid_q <= pushValid_d;
      pushData_q <= pushData_d;
      pullReq_q <= pullReq_d;
      pcLoad_q <= pcLoad_d;
      pcValue_q <= pcValue_d;
      queueRefill_q <= queueRefill_d;
    end
  end

  // ---------------------------------------------------------------
  // External pin registers
  // ---------------------------------------------------------------
  // Pins registered; lines idle at zero and emulation select high when disabled
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      xa_q <= PPGX_PAGE_RST;
      xaOe_q <= 1'b0;
      ecsN_q <= 1'b1;
      xcsN_q <= 1'b1;
    end
    else
    begin
      xa_q <= pinsEnabled ? xaNext : PPGX_PAGE_RST;
      xaOe_q <= pinsEnabled;
      ecsN_q <= ~emuActive;
      xcsN_q <= ~xcsActive;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign programPageIndex = page_q;
  assign pushValid = pushValid_q;
  assign pushData = pushData_q;
  assign pullReq = pullReq_q;
  assign pcLoad = pcLoad_q;
  assign pcValue = pcValue_q;
  assign queueRefill = queueRefill_q;
  assign seqBusy = busy_q;
  assign irqBlock = busy_q;
  assign extendedAddrHigh = xa_q;
  assign extAddrOe = xaOe_q;
  assign emuChipSelectN = ecsN_q;
  assign extChipSelectN = xcsN_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence callSeq;
    pushValid_q ##1 pushValid_q ##1 pushValid_q ##1 pcLoad_q;
  endsequence

  sequence rtcSeq;
    pullReq_q ##1 pullReq_q ##1 pullReq_q ##1 !pullReq_q ##1 pcLoad_q;
  endsequence

  AST_CALL_PAGE: assert property (@(posedge clock) disable iff (rst)
    (state_q == PPGX_IDLE && callStart) |=> (page_q == $past(callPage)))
    else $error("call page not loaded");
  AST_CALL_ORDER: assert property (@(posedge clock) disable iff (rst)
    (state_q == PPGX_IDLE && callStart) |=> callSeq)
    else $error("call push order wrong");
  AST_CALL_OLDPAGE: assert property (@(posedge clock) disable iff (rst)
    (state_q == PPGX_IDLE && callStart) |=> ##2 (pushData_q[5:0] == $past(page_q, 3)))
    else $error("old page not pushed");
  AST_CALL_JUMP: assert property (@(posedge clock) disable iff (rst)
    (state_q == PPGX_IDLE && callStart) |=> ##3 (pcValue_q == $past(callTarget, 4) && queueRefill_q))
    else $error("call target wrong");
  AST_NO_IRQ: assert property (@(posedge clock) disable iff (rst)
    (state_q != PPGX_IDLE) |-> irqBlock)
    else $error("sequence interruptible");
  AST_RTC_SEQ: assert property (@(posedge clock) disable iff (rst)
    (state_q == PPGX_IDLE && !callStart && rtcStart) |=> rtcSeq)
    else $error("return sequence wrong");
  AST_RTC_PAGE: assert property (@(posedge clock) disable iff (rst)
    (state_q == PPGX_RTC_RETHI) |=> ##2 (page_q == $past(pullData, 3)))
    else $error("return page not restored");
  AST_WRITE: assert property (@(posedge clock) disable iff (rst)
    (state_q == PPGX_IDLE && !callStart && !rtcStart && pageWrite)
    |=> (page_q == $past(pageWriteData)))
    else $error("page write not effective");
  AST_PINS_OFF: assert property (@(posedge clock) disable iff (rst)
    !pinsEnabled |=> (emuChipSelectN && !extAddrOe))
    else $error("pins active while disabled");
  AST_XCS: assert property (@(posedge clock) disable iff (rst)
    !extChipSelectN |-> emuChipSelectN)
    else $error("both selects active");
  AST_TOP_ECS: assert property (@(posedge clock) disable iff (rst)
    (pinsEnabled && addrValid && quadrant == PPGX_QUAD_TOP)
    |=> (!emuChipSelectN && extendedAddrHigh == PPGX_XA_TOP))
    else $error("top block not selected");
endmodule
`default_nettype wire

// *** ppgx_stack_model.sv ***
// Stack memory model on the far side of the call/return sequencer.
// Assumes single-cycle push and pull strobes from the page block.
`timescale 1ns/100ps
`default_nettype none
module ppgx_stack_model
(
  input wire logic clock,
  input wire logic rst,
  input wire logic pushValid,
  input wire logic [7:0] pushData,
  input wire logic pullReq,
  output logic [7:0] pullData
);
  // ---------------------------------------------------------------
  // Stack storage
  // ---------------------------------------------------------------
  logic [7:0] mem [0:255];
  logic [7:0] sp;
  // Push stores at the pointer; a pull answers in the next cycle only
  always @(posedge clock)
  begin
    if (rst)
    begin
      sp <= 8'h00;
      pullData <= 8'h5a;
    end
    else
    begin
      if (pushValid)
      begin
        mem[sp] <= pushData;
        sp <= sp + 8'h01;
      end
      if (pullReq)
      begin
        pullData <= mem[sp - 8'h01];
        sp <= sp - 8'h01;
      end
      else
        pullData <= ~pullData; // Stale byte never looks valid
    end
  end
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the program page expansion block.
// Assumes the stack model answers each pull in the following cycle.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    comparisons++; \
    if ((got) !== (ex)) \
    begin \
      badCount++; \
      $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
    end \
  end
module testbench;
  import ppgx_pkg::*;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [1:0] partitionSelect = 2'h0;
  logic [1:0] allocSize = 2'h0;
  logic romHighMapHide = 1'h0;
  logic emulationPortEnable = 1'h0;
  logic expandedMode = 1'h0;
  logic pageWrite = 1'h0;
  logic [5:0] pageWriteData = 6'h00;
  logic [15:0] coreAddr = 16'h0000;
  logic addrValid = 1'h0;
  logic extSpace = 1'h0;
  logic callStart = 1'h0;
  logic [5:0] callPage = 6'h00;
  logic [15:0] callTarget = 16'h0000;
  logic [15:0] callReturnAddr = 16'h0000;
  logic rtcStart = 1'h0;
  logic [7:0] pullData;
  logic [5:0] programPageIndex;
  logic pushValid, pullReq, pcLoad, queueRefill, seqBusy, irqBlock;
  logic [7:0] pushData;
  logic [15:0] pcValue;
  logic [5:0] extendedAddrHigh;
  logic extAddrOe, emuChipSelectN, extChipSelectN;
  int badCount = 0;
  int comparisons = 0;
  int seed = 24991;
  logic [5:0] pg, oldPg, newPg, xa;
  logic [15:0] tgt, ret;
  logic [1:0] q;
  logic ecsAct, pinsOn;
  logic [5:0] corners [0:7] = '{6'h37, 6'h38, 6'h2f, 6'h30, 6'h1f, 6'h20, 6'h00, 6'h3f};
  // Clock at 200 MHz
  initial
  begin
    forever #2.5 clock = ~clock;
  end
  // ---------------------------------------------------------------
  // Design and far-side stack
  // ---------------------------------------------------------------
  ppgx_program_page DUT (.clock, .rst, .partitionSelect, .allocSize, .romHighMapHide,
    .emulationPortEnable, .expandedMode, .pageWrite, .pageWriteData, .programPageIndex,
    .coreAddr, .addrValid, .extSpace, .callStart, .callPage, .callTarget, .callReturnAddr,
    .rtcStart, .pullData, .pushValid, .pushData, .pullReq, .pcLoad, .pcValue, .queueRefill,
    .seqBusy, .irqBlock, .extendedAddrHigh, .extAddrOe, .emuChipSelectN, .extChipSelectN);
  ppgx_stack_model stack (.clock, .rst, .pushValid, .pushData, .pullReq, .pullData);
  // ---------------------------------------------------------------
  // Expectation functions
  // ---------------------------------------------------------------
  // Window page internal for the given partition
  function automatic logic inPage(input logic [1:0] part, input logic [5:0] p);
    case (part)
      2'h0: return p >= 6'h38;
      2'h1: return p >= 6'h30;
      2'h2: return p >= 6'h20;
      default: return 1'h1;
    endcase
  endfunction
  // Emulation select decode per allocated size and quadrant
  function automatic logic ecsOn(input logic [1:0] al, input logic [1:0] qd,
                                 input logic intl, input logic hm);
    case (al)
      2'h0: return qd[1];
      2'h1: return qd == 2'h3;
      2'h2: return (qd == 2'h3) | ((qd == 2'h2) & intl) | ((qd == 2'h1) & !hm);
      default: return (qd == 2'h3) | ((qd == 2'h2) & intl) | (!qd[1] & !hm);
    endcase
  endfunction
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  // Reset with a new static configuration, checking reset values
  task automatic resetDut(input logic [3:0] cfg);
    @(posedge clock);
    rst <= 1'h1;
    partitionSelect <= cfg[1:0];
    allocSize <= cfg[3:2];
    repeat (2) @(posedge clock);
    #1;
    `CHK("resetPage", 6'h00, programPageIndex);
    `CHK("resetEcs", 1'h1, emuChipSelectN);
    `CHK("resetXcs", 1'h1, extChipSelectN);
    `CHK("resetOe", 1'h0, extAddrOe);
    @(posedge clock);
    rst <= 1'h0;
  endtask
  // One random access, pins checked one cycle later
  task automatic pinAccess();
    @(posedge clock);
    coreAddr <= 16'($random(seed));
    romHighMapHide <= 1'($random(seed));
    emulationPortEnable <= (2'($random(seed)) != 2'h0);
    expandedMode <= (2'($random(seed)) != 2'h0);
    extSpace <= 1'($random(seed));
    addrValid <= 1'h1;
    @(posedge clock);
    #1;
    q = coreAddr[15:14];
    pinsOn = emulationPortEnable & expandedMode;
    ecsAct = pinsOn & ecsOn(allocSize, q, inPage(partitionSelect, pg), romHighMapHide);
    xa = (q == 2'h2) ? pg : (q == 2'h0) ? 6'h3d : (q == 2'h1) ? 6'h3e : 6'h3f;
    if (!pinsOn)
      xa = 6'h00;
    `CHK("emuSel", !ecsAct, emuChipSelectN);
    `CHK("extAddr", xa, extendedAddrHigh);
    `CHK("extAddrOe", pinsOn, extAddrOe);
    `CHK("extSel", !(emulationPortEnable & extSpace & !ecsAct), extChipSelectN);
  endtask
  // Far call with a page write landing while busy
  task automatic farCall();
    tgt = 16'($random(seed));
    ret = 16'($random(seed));
    newPg = 6'($random(seed));
    @(posedge clock);
    callStart <= 1'h1;
    callPage <= newPg;
    callTarget <= tgt;
    callReturnAddr <= ret;
    @(posedge clock);
    callStart <= 1'h0;
    callPage <= ~newPg;
    callTarget <= ~tgt;
    pageWrite <= 1'h1;
    pageWriteData <= ~newPg;
    #1;
    `CHK("callPage", newPg, programPageIndex);
    `CHK("pushLo", ret[7:0], pushData);
    `CHK("pushValid", 1'h1, pushValid);
    `CHK("irqBlock", 1'h1, irqBlock);
    @(posedge clock);
    pageWrite <= 1'h0;
    #1;
    `CHK("pushHi", ret[15:8], pushData);
    `CHK("busyPage", newPg, programPageIndex);
    @(posedge clock);
    #1;
    `CHK("pushPage", {2'h0, pg}, pushData);
    `CHK("seqBusy", 1'h1, seqBusy);
    @(posedge clock);
    #1;
    `CHK("callPc", tgt, pcValue);
    `CHK("callLoad", 2'h3, {pcLoad, queueRefill});
    `CHK("callIdle", 3'h0, {seqBusy, irqBlock, pushValid});
    oldPg = pg;
    pg = newPg;
  endtask
  // Far return: three pulls, then page and counter restored
  task automatic farReturn();
    @(posedge clock);
    rtcStart <= 1'h1;
    @(posedge clock);
    rtcStart <= 1'h0;
    for (int k = 0; k < 4; k++)
    begin
      #1;
      `CHK("pullReq", 1'(k < 3), pullReq);
      `CHK("rtcBusy", 2'h3, {seqBusy, irqBlock});
      `CHK("rtcHold", pg, programPageIndex);
      @(posedge clock);
    end
    #1;
    `CHK("rtcPc", ret, pcValue);
    `CHK("rtcLoad", 2'h3, {pcLoad, queueRefill});
    `CHK("rtcPage", oldPg, programPageIndex);
    pg = oldPg;
  endtask
  // Prints the counts and the verdict, then ends the run
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence over every partition and allocation code
  // ---------------------------------------------------------------
  initial
  begin
    for (int c = 0; c < 16; c++)
    begin
      resetDut(4'(c));
      pg = corners[(c + c / 4) % 8];
      @(posedge clock);
      pageWrite <= 1'h1;
      pageWriteData <= ~pg;
      @(posedge clock);
      pageWriteData <= pg;
      #1;
      `CHK("writeFirst", ~pg, programPageIndex);
      @(posedge clock);
      pageWrite <= 1'h0;
      #1;
      `CHK("writeSecond", pg, programPageIndex);
      repeat (12) pinAccess();
      farCall();
      repeat (12) pinAccess();
      farReturn();
      repeat (4) pinAccess();
    end
    conclude();
  end
  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clock);
    badCount++;
    conclude();
  end
endmodule
`default_nettype wire
